// File: shared/sdmbc_defs.svh
// Constants for the synchronous DRAM mode and burst core.
// Assumes inclusion by bare name from the package file.
`ifndef SDMBC_DEFS_SVH
`define SDMBC_DEFS_SVH

// ----------------------------------------
// Organisation
// ----------------------------------------
`define SDMBC_BANKS 4
`define SDMBC_ROWS 4096
`define SDMBC_COLS 256
`define SDMBC_DATA_W 16
`define SDMBC_ROW_W 12
`define SDMBC_COL_W 8
`define SDMBC_CFG_W 14

// ----------------------------------------
// Configuration word fields
// ----------------------------------------
`define SDMBC_BL_LSB 0
`define SDMBC_BL_MSB 2
`define SDMBC_BT_BIT 3
`define SDMBC_CL_LSB 4
`define SDMBC_CL_MSB 6
`define SDMBC_OM_LSB 7
`define SDMBC_OM_MSB 8
`define SDMBC_CFG_RESET 14'h0000

// ----------------------------------------
// Encodings
// ----------------------------------------
`define SDMBC_BL_1 3'h0
`define SDMBC_BL_2 3'h1
`define SDMBC_BL_4 3'h2
`define SDMBC_BL_8 3'h3
`define SDMBC_BL_PAGE 3'h7
`define SDMBC_CL_2 3'h2
`define SDMBC_CL_3 3'h3
`define SDMBC_OM_NORMAL 2'h0

// ----------------------------------------
// Latency pipe
// ----------------------------------------
`define SDMBC_PIPE_W 4

`endif

// File: shared/sdmbc_pkg.sv
// Types for the synchronous DRAM mode and burst core.
// Assumes the constants header sits in the include path.
`include "sdmbc_defs.svh"

package sdmbc_pkg;

	typedef enum logic [3:0] {
		SDMBC_CMD_INHIBIT,
		SDMBC_CMD_NOP,
		SDMBC_CMD_ACTIVE,
		SDMBC_CMD_READ,
		SDMBC_CMD_WRITE,
		SDMBC_CMD_TERM,
		SDMBC_CMD_PRECH,
		SDMBC_CMD_REFRESH,
		SDMBC_CMD_LOADCFG
	} sdmbc_cmd_t;

	typedef struct packed {
		logic chipSelectN;
		logic rowStrobeN;
		logic colStrobeN;
		logic writeEnableN;
	} sdmbc_pins_t;

	typedef struct packed {
		logic [1:0] bank;
		logic [`SDMBC_COL_W-1:0] col;
		logic [`SDMBC_DATA_W-1:0] data;
	} sdmbc_word_t;

endpackage

// File: hw/sdmbc_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock, active-high asynchronous reset.
module sdmbc_fifo
	import sdmbc_pkg::*;
#(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic clkEn,
	// Fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// Drain side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_reg;
	logic [AW-1:0] rdPtr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;

	assign inReady = (count_reg != DEPTH[AW:0]);
	assign outValid = (count_reg != '0);
	assign outData = mem[rdPtr_reg];
	assign push = clkEn && inValid && inReady;
	assign pop = clkEn && outValid && outReady;

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wrPtr_reg] <= inData;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wrPtr_reg <= (wrPtr_reg == AW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
			end
			if (pop) begin
				rdPtr_reg <= (rdPtr_reg == AW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

	chk_fifo_bound: assert property (@(posedge sys_clk) disable iff (reset)
		count_reg <= DEPTH[AW:0]) else $error("FIFO count beyond depth");
endmodule

// File: hw/sdmbc_core.sv
// Command core of a four-bank synchronous DRAM: decode, config word, bursts.
// Assumes an external controller drives pins on sys_clk; the data pin
// level is resolved outside from dqOut and the active-low enable.
//
// Behaviour
// - Four banks, 4096 rows, 256 columns, 16-bit
// - Inputs sampled only on rising clock edge
// - ACTIVE takes bank and twelve-bit row
// - READ/WRITE start column from low address
// - Config undefined until loaded before operation
// - Config held until next load
// - Config fields: length, order, latency, mode
// - Burst lengths 1,2,4,8 both orders
// - Full page only sequential order
// - Full page wraps in row, terminate
// - Burst block fixed by upper column bits
// - Sequential order steps offset modulo length
// - Interleaved order XORs start with counter
// - Read latency two or three clocks
// - Drive data pins one cycle early
// - Normal mode needs both mode bits zero
// - Burst length governs reads and writes
module sdmbc_core
	import sdmbc_pkg::*;
#(
	parameter int BANKS = `SDMBC_BANKS,
	parameter int ROW_W = `SDMBC_ROW_W,
	parameter int COL_W = `SDMBC_COL_W,
	parameter int DATA_W = `SDMBC_DATA_W,
	parameter int FIFO_DEPTH = 4
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic clkEn,
	// Command pins
	input wire sdmbc_pins_t cmdPins,
	input wire logic bank_select_low,
	input wire logic bank_select_high,
	input wire logic [ROW_W-1:0] row_column_address_bits,
	// Data pins
	input wire logic [DATA_W-1:0] dqIn,
	output logic [DATA_W-1:0] dqOut,
	output logic dqOeN,
	// Status
	output logic cfgLoaded,
	output logic normalMode,
	// Write stream out
	output logic wrValid,
	input wire logic wrReady,
	output sdmbc_word_t wrWord
);
	localparam int CFG_W = `SDMBC_CFG_W;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic sdmbc_cmd_t decodeCmd(input sdmbc_pins_t p);
		if (p.chipSelectN) begin
			return SDMBC_CMD_INHIBIT;
		end
		case ({p.rowStrobeN, p.colStrobeN, p.writeEnableN})
			3'h7: return SDMBC_CMD_NOP;
			3'h3: return SDMBC_CMD_ACTIVE;
			3'h5: return SDMBC_CMD_READ;
			3'h4: return SDMBC_CMD_WRITE;
			3'h6: return SDMBC_CMD_TERM;
			3'h2: return SDMBC_CMD_PRECH;
			3'h1: return SDMBC_CMD_REFRESH;
			default: return SDMBC_CMD_LOADCFG;
		endcase
	endfunction

	// Mask of offset bits wrapping inside the block
	function automatic logic [COL_W-1:0] blockMask(input logic [2:0] bl);
		case (bl)
			`SDMBC_BL_2: return COL_W'(8'h01);
			`SDMBC_BL_4: return COL_W'(8'h03);
			`SDMBC_BL_8: return COL_W'(8'h07);
			`SDMBC_BL_PAGE: return '1;
			default: return '0;
		endcase
	endfunction

	// Column for beat k of a burst
	function automatic logic [COL_W-1:0] beatCol(input logic [COL_W-1:0] start,
		input logic [COL_W-1:0] k, input logic [2:0] bl, input logic inter);
		logic [COL_W-1:0] m;
		logic [COL_W-1:0] off;
		m = blockMask(bl);
		if (inter && bl != `SDMBC_BL_PAGE) begin
			off = start ^ k;
		end else begin
			off = start + k;
		end
		return (start & ~m) | (off & m);
	endfunction

	// ----------------------------------------
	// Command decode and configuration word
	// ----------------------------------------
	sdmbc_cmd_t cmd;
	logic [1:0] bankIn;
	logic [CFG_W-1:0] operation_config_word_reg;
	logic [2:0] burst_length_field;
	logic burst_order_bit;
	logic [2:0] read_latency_field;
	logic operating_mode_low;
	logic operating_mode_high;
	logic [4:0] reserved_config_bits;

	assign cmd = decodeCmd(cmdPins);
	assign bankIn = {bank_select_high, bank_select_low};
	assign burst_length_field = operation_config_word_reg[`SDMBC_BL_MSB:`SDMBC_BL_LSB];
	assign burst_order_bit = operation_config_word_reg[`SDMBC_BT_BIT];
	assign read_latency_field = operation_config_word_reg[`SDMBC_CL_MSB:`SDMBC_CL_LSB];
	assign operating_mode_low = operation_config_word_reg[`SDMBC_OM_LSB];
	assign operating_mode_high = operation_config_word_reg[`SDMBC_OM_MSB];
	assign reserved_config_bits = operation_config_word_reg[CFG_W-1:`SDMBC_OM_MSB+1];

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			operation_config_word_reg <= `SDMBC_CFG_RESET;
			cfgLoaded <= 1'b0;
			normalMode <= 1'b0;
		end else if (clkEn && cmd == SDMBC_CMD_LOADCFG) begin
			// Only a load changes it; held otherwise
			operation_config_word_reg <= CFG_W'({bank_select_high, bank_select_low, row_column_address_bits});
			cfgLoaded <= 1'b1;
			normalMode <= (row_column_address_bits[`SDMBC_OM_MSB:`SDMBC_OM_LSB] == `SDMBC_OM_NORMAL);
		end
	end

	// ----------------------------------------
	// Row tracking
	// ----------------------------------------
	logic [ROW_W-1:0] openRow_reg [BANKS];
	logic [BANKS-1:0] rowOpen_reg;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rowOpen_reg <= '0;
			for (int i = 0; i < BANKS; i++) begin
				openRow_reg[i] <= '0;
			end
		end else if (clkEn) begin
			if (cmd == SDMBC_CMD_ACTIVE) begin
				openRow_reg[bankIn] <= row_column_address_bits;
				rowOpen_reg[bankIn] <= 1'b1;
			end else if (cmd == SDMBC_CMD_PRECH) begin
				// Address bit 10 selects all banks
				if (row_column_address_bits[10]) begin
					rowOpen_reg <= '0;
				end else begin
					rowOpen_reg[bankIn] <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------
	// Burst sequencer
	// ----------------------------------------
	logic busy_reg;
	logic isRead_reg;
	logic [1:0] burstBank_reg;
	logic [COL_W-1:0] startCol_reg;
	logic [COL_W-1:0] beat_reg;
	logic [COL_W-1:0] curCol;
	logic lastBeat;
	logic fifoReady;
	logic memReadBeat;

	// Words in the array: one per bank, row, column
	logic [DATA_W-1:0] mem [BANKS * (1 << ROW_W) * (1 << COL_W)];

	assign curCol = beatCol(startCol_reg, beat_reg, burst_length_field, burst_order_bit);
	// Same length for reads and writes
	assign lastBeat = (burst_length_field != `SDMBC_BL_PAGE) && (beat_reg == blockMask(burst_length_field));
	assign memReadBeat = busy_reg && isRead_reg;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			busy_reg <= 1'b0;
			isRead_reg <= 1'b0;
			burstBank_reg <= '0;
			startCol_reg <= '0;
			beat_reg <= '0;
		end else if (clkEn) begin
			if (cmd == SDMBC_CMD_READ || cmd == SDMBC_CMD_WRITE) begin
				busy_reg <= 1'b1;
				isRead_reg <= (cmd == SDMBC_CMD_READ);
				burstBank_reg <= bankIn;
				startCol_reg <= row_column_address_bits[COL_W-1:0];
				beat_reg <= '0;
			end else if (cmd == SDMBC_CMD_TERM || cmd == SDMBC_CMD_PRECH) begin
				busy_reg <= 1'b0;
			end else if (busy_reg && (isRead_reg || fifoReady)) begin
				// Full page never ends by count; wraps in row
				busy_reg <= !lastBeat;
				beat_reg <= beat_reg + 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Write data path through FIFO
	// ----------------------------------------
	logic wrBeat;
	sdmbc_word_t wrIn;
	logic wrValid_int;
	logic [$bits(sdmbc_word_t)-1:0] wrOutData_int;

	// Write beats: first word arrives with the command, later on each edge
	assign wrBeat = clkEn && ((cmd == SDMBC_CMD_WRITE) || (busy_reg && !isRead_reg && cmd != SDMBC_CMD_READ
		&& cmd != SDMBC_CMD_TERM && cmd != SDMBC_CMD_PRECH && !lastBeat));
	assign wrIn.bank = (cmd == SDMBC_CMD_WRITE) ? bankIn : burstBank_reg;
	assign wrIn.col = (cmd == SDMBC_CMD_WRITE) ? row_column_address_bits[COL_W-1:0]
		: beatCol(startCol_reg, beat_reg + 1'b1, burst_length_field, burst_order_bit);
	assign wrIn.data = dqIn;

	// Full FIFO stalls the write beat counter; incoming words are lost then
	sdmbc_fifo #(
		.WIDTH($bits(sdmbc_word_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.reset(reset),
		.clkEn(clkEn),
		.inValid(wrBeat),
		.inReady(fifoReady),
		.inData(wrIn),
		.outValid(wrValid_int),
		.outReady(wrReady),
		.outData(wrOutData_int)
	);

	// Drains one word per cycle while wrReady is high, so a burst of eight then never overflows the buffer
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			wrValid <= 1'b0;
			wrWord <= '0;
		end else if (clkEn) begin
			if (wrValid_int && wrReady) begin
				wrValid <= 1'b1;
				wrWord <= wrOutData_int;
			end else begin
				wrValid <= 1'b0;
			end
		end
	end

	// Stored words land in the array as they are drained
	always_ff @(posedge sys_clk) begin
		if (clkEn && wrValid) begin
			mem[{wrWord.bank, openRow_reg[wrWord.bank], wrWord.col}] <= wrWord.data;
		end
	end

	// ----------------------------------------
	// Read latency pipe and data pins
	// ----------------------------------------
	logic [`SDMBC_PIPE_W-1:0] validPipe_reg;
	logic [DATA_W-1:0] dataPipe_reg [`SDMBC_PIPE_W];
	logic [DATA_W-1:0] fetched;
	logic issue;
	int unsigned lat;

	assign fetched = mem[{burstBank_reg, openRow_reg[burstBank_reg], curCol}];
	// Beat fetched at the stop edge still leaves; later beats are cut
	assign issue = memReadBeat;
	assign lat = (read_latency_field == `SDMBC_CL_3) ? 3 : 2;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			validPipe_reg <= '0;
			for (int i = 0; i < `SDMBC_PIPE_W; i++) begin
				dataPipe_reg[i] <= '0;
			end
		end else if (clkEn) begin
			validPipe_reg <= {validPipe_reg[`SDMBC_PIPE_W-2:0], issue};
			dataPipe_reg[0] <= fetched;
			for (int i = 1; i < `SDMBC_PIPE_W; i++) begin
				dataPipe_reg[i] <= dataPipe_reg[i-1];
			end
		end
	end

	// Beat issued at edge n+1 shows at edge n+m; pins enabled one edge earlier
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			dqOut <= '0;
			dqOeN <= 1'b1;
		end else if (clkEn) begin
			dqOut <= dataPipe_reg[lat - 2];
			// Enable as soon as next word is queued, release after last
			dqOeN <= !(validPipe_reg[lat - 2] || (lat == 3 ? validPipe_reg[0] : issue));
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_cfg_hold: assert property (@(posedge sys_clk) disable iff (reset)
		cmd != SDMBC_CMD_LOADCFG |=> $stable(operation_config_word_reg)) else $error("Config changed without load");
	chk_row_capture: assert property (@(posedge sys_clk) disable iff (reset)
		clkEn && cmd == SDMBC_CMD_ACTIVE |=> openRow_reg[$past(bankIn)] == $past(row_column_address_bits))
		else $error("Row not captured");
	chk_col_capture: assert property (@(posedge sys_clk) disable iff (reset)
		clkEn && cmd == SDMBC_CMD_READ |=> startCol_reg == $past(row_column_address_bits[COL_W-1:0]))
		else $error("Start column not captured");
	chk_block_stay: assert property (@(posedge sys_clk) disable iff (reset)
		busy_reg |-> ((curCol & ~blockMask(burst_length_field)) == (startCol_reg & ~blockMask(burst_length_field))))
		else $error("Burst left its block");
	chk_seq_step: assert property (@(posedge sys_clk) disable iff (reset)
		busy_reg && !burst_order_bit && beat_reg == '0 |-> curCol == startCol_reg) else $error("First beat wrong");
	chk_mode_flag: assert property (@(posedge sys_clk) disable iff (reset)
		clkEn && cmd == SDMBC_CMD_LOADCFG |=> normalMode == ($past(row_column_address_bits[8:7]) == 2'h0))
		else $error("Mode flag wrong");
	chk_len_one: assert property (@(posedge sys_clk) disable iff (reset)
		clkEn && cmd == SDMBC_CMD_READ && burst_length_field == `SDMBC_BL_1 ##1 clkEn && cmd == SDMBC_CMD_NOP
		|=> !busy_reg) else $error("Length one burst overran");
	chk_release: assert property (@(posedge sys_clk) disable iff (reset)
		clkEn && validPipe_reg == '0 && !issue |=> dqOeN) else $error("Pins driven with no data");

	cov_read: cover property (@(posedge sys_clk) disable iff (reset) !dqOeN);
	cov_write: cover property (@(posedge sys_clk) disable iff (reset) wrValid);
	cov_page: cover property (@(posedge sys_clk) disable iff (reset) busy_reg && burst_length_field == `SDMBC_BL_PAGE);
	cov_inter: cover property (@(posedge sys_clk) disable iff (reset) busy_reg && burst_order_bit);
	cov_term: cover property (@(posedge sys_clk) disable iff (reset) busy_reg && cmd == SDMBC_CMD_TERM);
endmodule

// File: dv/sdmbc_ctl_model.sv
// Controller model: drives command, address and write data pins.
// Assumes the bench calls its tasks and supplies sys_clk.
module sdmbc_ctl_model
	import sdmbc_pkg::*;
#(
	parameter int WAIT_CYC = 1000
) (
	// Clock
	input wire logic sys_clk,
	// Command and address
	output sdmbc_pins_t cmdPins,
	output logic bank_select_low,
	output logic bank_select_high,
	output logic [11:0] row_column_address_bits,
	// Write data
	output logic [15:0] dqIn
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		cmdPins = 4'hf;
		bank_select_low = 1'b0;
		bank_select_high = 1'b0;
		row_column_address_bits = 12'h000;
		dqIn = 16'h5a5a;
	end

	// ----------------------------------------
	// Command driver
	// ----------------------------------------
	task automatic issue(input sdmbc_cmd_t c, input logic [1:0] ba, input logic [11:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		#10;
		case (c)
			SDMBC_CMD_INHIBIT: cmdPins = 4'hf;
			SDMBC_CMD_NOP: cmdPins = 4'h7;
			SDMBC_CMD_ACTIVE: cmdPins = 4'h3;
			SDMBC_CMD_READ: cmdPins = 4'h5;
			SDMBC_CMD_WRITE: cmdPins = 4'h4;
			SDMBC_CMD_TERM: cmdPins = 4'h6;
			SDMBC_CMD_PRECH: cmdPins = 4'h2;
			SDMBC_CMD_REFRESH: cmdPins = 4'h1;
			default: cmdPins = 4'h0;
		endcase
		bank_select_high = ba[1];
		bank_select_low = ba[0];
		row_column_address_bits = a;
		dqIn = d;
	endtask

	// Data line is not held outside write beats: it flips every cycle
	task automatic nop(input int n);
		repeat (n) issue(SDMBC_CMD_NOP, 2'h0, 12'h000, ~dqIn);
	endtask

	// ----------------------------------------
	// Power-up and configuration
	// ----------------------------------------
	task automatic init_seq();
		issue(SDMBC_CMD_INHIBIT, 2'h0, 12'h000, ~dqIn);
		nop(WAIT_CYC);
		issue(SDMBC_CMD_PRECH, 2'h0, 12'h400, ~dqIn);
		nop(1);
		repeat (2) begin
			issue(SDMBC_CMD_REFRESH, 2'h0, 12'h000, ~dqIn);
			nop(2);
		end
	endtask

	// Only called with all banks idle, normal or chosen mode encodings
	task automatic load_cfg(input logic [13:0] w);
		issue(SDMBC_CMD_LOADCFG, w[13:12], w[11:0], ~dqIn);
		nop(2);
	endtask
endmodule

// File: dv/sdmbc_core_test.sv
// Self-checking bench for the mode and burst core.
// Assumes the controller model in dv/ and the package in shared/.
module sdmbc_core_test
	import sdmbc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic wrReady = 1'b1;
	logic clkEn = 1'b1;
	sdmbc_pins_t cmdPins;
	logic bank_select_low, bank_select_high, dqOeN, cfgLoaded, normalMode, wrValid;
	logic [11:0] row_column_address_bits;
	logic [15:0] dqIn, dqOut;
	sdmbc_word_t wrWord;
	int fails = 0;
	int num_checks = 0;
	int seed = 18207;
	logic [15:0] memModel [int];
	sdmbc_word_t expQ [$];

	initial forever #50 sys_clk = ~sys_clk;

	sdmbc_ctl_model i_ctl (.sys_clk(sys_clk), .cmdPins(cmdPins), .bank_select_low(bank_select_low),
		.bank_select_high(bank_select_high), .row_column_address_bits(row_column_address_bits), .dqIn(dqIn));

	// Clock enable driven: one scenario freezes the core during a load
	sdmbc_core i_dut (.sys_clk(sys_clk), .reset(reset), .clkEn(clkEn), .cmdPins(cmdPins),
		.bank_select_low(bank_select_low), .bank_select_high(bank_select_high),
		.row_column_address_bits(row_column_address_bits), .dqIn(dqIn), .dqOut(dqOut), .dqOeN(dqOeN),
		.cfgLoaded(cfgLoaded), .normalMode(normalMode), .wrValid(wrValid), .wrReady(wrReady), .wrWord(wrWord));

	// ----------------------------------------
	// Compare and closing tasks
	// ----------------------------------------
	task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t read word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp, input string what);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t %s is %b expected %b", $time, what, got, exp);
		end
	endtask

	task automatic check_wr(input sdmbc_word_t got, input sdmbc_word_t exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t write word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("Checks made %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ----------------------------------------
	// Reference model
	// ----------------------------------------
	function automatic int col_at(int s, int k, int bl, int inter);
		if (bl == 256)
			return (s + k) % 256;
		if (inter != 0)
			return (s & ~(bl - 1)) | ((s ^ k) & (bl - 1));
		return (s & ~(bl - 1)) | ((s + k) & (bl - 1));
	endfunction

	// Write stream leaves in burst order; sampled mid-cycle where settled
	always @(negedge sys_clk) begin
		if (wrValid === 1'b1) begin
			if (expQ.size() == 0) begin
				fails++;
				$display("ERROR %0t unexpected write word", $time);
			end else
				check_wr(wrWord, expQ.pop_front());
		end
	end

	task automatic do_write(input int ba, input int s, input int n, input int bl, input int inter);
		int c;
		logic [15:0] d;
		for (int k = 0; k < n; k++) begin
			c = col_at(s, k, bl, inter);
			d = 16'($random(seed));
			memModel[ba * 256 + c] = d;
			expQ.push_back({ba[1:0], c[7:0], d});
			if (k == 0)
				i_ctl.issue(SDMBC_CMD_WRITE, ba[1:0], {4'h0, s[7:0]}, d);
			else
				i_ctl.issue(SDMBC_CMD_NOP, ba[1:0], 12'h000, d);
		end
		if (bl == 256)
			i_ctl.issue(SDMBC_CMD_TERM, 2'h0, 12'h000, ~dqIn);
		i_ctl.nop(2);
	endtask

	task automatic drain(input int stall);
		int w;
		for (w = 0; w < 200 && expQ.size() > 0; w++) begin
			@(posedge sys_clk);
			#10;
			wrReady = (stall != 0) ? 1'($random(seed)) : 1'b1;
		end
		wrReady = 1'b1;
		i_ctl.nop(2);
		check_bit(expQ.size() == 0, 1'b1, "write stream drained");
	endtask

	task automatic do_read(input int ba, input int s, input int n, input int bl, input int inter, input int cl);
		i_ctl.issue(SDMBC_CMD_READ, ba[1:0], {4'h0, s[7:0]}, ~dqIn);
		for (int j = 1; j <= cl + n + 1; j++) begin
			if (bl == 256 && j == n)
				i_ctl.issue(SDMBC_CMD_TERM, 2'h0, 12'h000, ~dqIn);
			else
				i_ctl.nop(1);
			if (j == cl - 1)
				check_bit(dqOeN, 1'b1, "early drive");
			if (j == cl)
				check_bit(dqOeN, 1'b0, "drive one cycle early");
			if (j > cl && j <= cl + n)
				check_word(dqOut, memModel[ba * 256 + col_at(s, j - cl - 1, bl, inter)]);
			if (j == cl + n + 1)
				check_bit(dqOeN, 1'b1, "release after burst");
		end
	endtask

	task automatic burst_pair(input int code, input int inter, input int cl, input int stall);
		int bl, ba, s, n;
		bl = (code == 7) ? 256 : (1 << code);
		n = (bl == 256) ? 6 : bl;
		ba = $random(seed) & 3;
		s = (bl == 256) ? 8'hfd : ($random(seed) & 8'hff);
		i_ctl.load_cfg({5'h00, 2'h0, cl[2:0], inter[0], code[2:0]});
		i_ctl.issue(SDMBC_CMD_ACTIVE, ba[1:0], 12'($random(seed)), ~dqIn);
		i_ctl.nop(2);
		if (stall != 0)
			wrReady = 1'b0;
		do_write(ba, s, n, bl, inter);
		drain(stall);
		do_read(ba, s, n, bl, inter, cl);
		i_ctl.nop(2);
		// Close every row so the next load finds all banks idle
		i_ctl.issue(SDMBC_CMD_PRECH, 2'h0, 12'h400, ~dqIn);
		i_ctl.nop(2);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge sys_clk);
		#10;
		reset = 1'b0;
		i_ctl.init_seq();
		check_bit(cfgLoaded, 1'b0, "loaded flag before load");
		i_ctl.load_cfg({5'h00, 2'h1, 3'h2, 1'b0, 3'h0});
		check_bit(cfgLoaded, 1'b1, "loaded flag");
		check_bit(normalMode, 1'b0, "test mode flag");
		i_ctl.load_cfg({5'h00, 2'h0, 3'h2, 1'b0, 3'h0});
		check_bit(normalMode, 1'b1, "normal mode flag");
		// A load seen while the clock enable is low must not land
		clkEn = 1'b0;
		i_ctl.load_cfg({5'h00, 2'h3, 3'h3, 1'b1, 3'h7});
		check_bit(normalMode, 1'b1, "mode flag frozen");
		clkEn = 1'b1;
		for (int code = 0; code < 8; code++) begin
			if (code > 3 && code < 7)
				continue;
			for (int t = 0; t < 2; t++)
				burst_pair(code, t, 2 + ((code + t) % 2), 0);
		end
		// Four beats fill the buffer while the sink stalls
		burst_pair(2, 0, 3, 1);
		wrap_up();
	end

	initial begin
		#2000000;
		fails++;
		$display("ERROR %0t run did not finish", $time);
		wrap_up();
	end
endmodule
